//--- sccc_consts.svh
// register offsets, field codes and reset values of the character conversion controller
`ifndef SCCC_CONSTS_SVH
`define SCCC_CONSTS_SVH
`define SCCC_OFF_CMD    8'h00
`define SCCC_OFF_STAT   8'h04
`define SCCC_OFF_WSIZE  8'h08
`define SCCC_OFF_LINES  8'h0c
`define SCCC_OFF_CFG0   8'h10
`define SCCC_OFF_CFG1   8'h14
`define SCCC_OFF_CFG2   8'h18
`define SCCC_OFF_CFG3   8'h1c
`define SCCC_CODE_CFG   8'h26
`define SCCC_CODE_CTRL  8'h22
`define SCCC_PORT_MAX   3'h4
`define SCCC_XL_LIGHT   2'h0
`define SCCC_XL_HEAVY   2'h1
`define SCCC_XL_NONE    2'h2
`define SCCC_IP_NONE    2'h0
`define SCCC_IP_ODD     2'h1
`define SCCC_IP_EVEN    2'h2
`define SCCC_IP_CLR     2'h3
`define SCCC_OP_KEEP    2'h0
`define SCCC_OP_ODD     2'h1
`define SCCC_OP_EVEN    2'h2
`define SCCC_OP_MARK    2'h3
`define SCCC_LC_OFF     2'h2
`define SCCC_LC_ON      2'h3
`define SCCC_XM_SPACE   2'h2
`define SCCC_XM_MARK    2'h3
`define SCCC_CH_ENDL    8'h9b
`define SCCC_CH_CR      8'h0d
`define SCCC_CH_LF      8'h0a
`define SCCC_HV_LO      7'h20
`define SCCC_HV_HI      7'h7c
`define SCCC_WS_8       2'h3
`define SCCC_AUX_RST    8'h00
`define SCCC_DTR_RST    4'h0
`define SCCC_RTS_RST    4'h0
`define SCCC_TXD_RST    4'hf
`endif

//--- sccc_pkg.sv
// types shared by the character conversion controller
`default_nettype none
package sccc_pkg;
  // packed option byte of a translation configure command
  typedef struct packed {
    logic       spare;
    logic       append_lf;
    logic [1:0] xlat;
    logic [1:0] in_par;
    logic [1:0] out_par;
  } sccc_opt_t;
  // one character and the port it belongs to
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] port;
  } sccc_chr_t;
  // command word as written to the command register
  typedef struct packed {
    logic [2:0] port_num;
    logic [7:0] second_aux_param;
    logic [7:0] first_aux_param;
    logic [7:0] code;
  } sccc_cmd_t;
  // outcome of the last command
  typedef enum logic [1:0] {
    SCCC_RES_IDLE,
    SCCC_RES_DONE,
    SCCC_RES_BUSY,
    SCCC_RES_BAD
  } sccc_res_t;
endpackage
`default_nettype wire

//--- sccc_ctrl.sv
// character conversion and line control for four serial ports, apb slave
`include "sccc_consts.svh"
`default_nettype none
module sccc_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              por,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              conc_active,
  input  wire logic              tx_in_valid,
  input  wire sccc_pkg::sccc_chr_t tx_in,
  output var  logic              tx_in_ready,
  output var  logic              tx_out_valid,
  output var  sccc_pkg::sccc_chr_t tx_out,
  input  wire logic              rx_in_valid,
  input  wire sccc_pkg::sccc_chr_t rx_in,
  output var  logic              rx_out_valid,
  output var  sccc_pkg::sccc_chr_t rx_out,
  output var  logic              rx_par_err,
  output var  logic [3:0]        dtr_line,
  output var  logic [3:0]        rts_line,
  output var  logic [3:0]        transmit_data_line
);

  // mask of the bits a word of the given size carries
  function automatic logic [7:0] ws_mask(input logic [1:0] ws);
    ws_mask = 8'hff >> (2'h3 - ws);
  endfunction

  // per-port persistent state, only power-on clears it
  sccc_pkg::sccc_opt_t opt_cfg [4];   // packed option byte
  logic [7:0]          subst   [4];   // substitute character
  logic [1:0]          wsize   [4];   // 0..3 means 5..8 bits

  // synchroniser for the concurrent-transfer flag
  logic conc_m;                       // first stage, read only by conc_s
  logic conc_s;                       // usable level

  // command outcome
  sccc_pkg::sccc_res_t last_res;

  // apb decode
  wire logic acc_phase = psel & penable;
  wire logic wr_en     = acc_phase & pready & pwrite;
  wire logic hit_cmd   = (paddr == `SCCC_OFF_CMD);
  wire logic hit_stat  = (paddr == `SCCC_OFF_STAT);
  wire logic hit_ws    = (paddr == `SCCC_OFF_WSIZE);
  wire logic hit_lines = (paddr == `SCCC_OFF_LINES);
  wire logic hit_cfg   = (paddr[7:4] == 4'h1) & (paddr[1:0] == 2'h0);
  wire logic addr_hit  = hit_cmd | hit_stat | hit_ws | hit_lines | hit_cfg;
  wire logic [1:0] cfg_sel = paddr[3:2];
  wire logic wr_cmd = wr_en & hit_cmd;
  wire logic wr_ws  = wr_en & hit_ws;

  // read selection; command register reads as zero
  wire logic [31:0] rd_mux =
    hit_stat  ? {29'h0, conc_s, last_res} :
    hit_ws    ? {24'h0, wsize[3], wsize[2], wsize[1], wsize[0]} :
    hit_lines ? {20'h0, transmit_data_line, rts_line, dtr_line} :
    hit_cfg   ? {16'h0, subst[cfg_sel], opt_cfg[cfg_sel]} :
                32'h0;

  // one wait state: data is captured on the same edge that raises pready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_phase & ~pready;
      if (acc_phase & ~pready) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~addr_hit;   // unmapped addresses answer with an error
      end
    end
  end

  // command decode
  wire sccc_pkg::sccc_cmd_t cmd = sccc_pkg::sccc_cmd_t'(pwdata[26:0]);
  wire logic port_ok  = (cmd.port_num <= `SCCC_PORT_MAX);
  wire logic [1:0] pidx = (cmd.port_num == 3'h0) ? 2'h0 : 2'(cmd.port_num - 3'h1);
  wire logic is_cfg   = (cmd.code == `SCCC_CODE_CFG);
  wire logic is_ctrl  = (cmd.code == `SCCC_CODE_CTRL);
  wire logic cmd_ok   = wr_cmd & ~conc_s & port_ok;
  wire logic do_cfg   = cmd_ok & is_cfg;
  wire logic do_ctrl  = cmd_ok & is_ctrl;
  // line control fields; the second parameter is never looked at
  wire logic [1:0] dtr_f = cmd.first_aux_param[7:6];
  wire logic [1:0] rts_f = cmd.first_aux_param[5:4];
  wire logic [1:0] txl_f = cmd.first_aux_param[1:0];
  // which lines exist on the selected port
  wire logic has_dtr = (pidx != 2'h3);
  wire logic has_rts = (pidx == 2'h0);

  // concurrent flag comes from another domain, two flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conc_m <= 1'b0;
      conc_s <= 1'b0;
    end else begin
      conc_m <= conc_active;
      conc_s <= conc_m;
    end
  end

  // record the outcome of each command write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_res <= sccc_pkg::SCCC_RES_IDLE;
    end else if (wr_cmd) begin
      if (conc_s) begin
        last_res <= sccc_pkg::SCCC_RES_BUSY;
      end else if (!port_ok || !(is_cfg || is_ctrl)) begin
        last_res <= sccc_pkg::SCCC_RES_BAD;
      end else begin
        last_res <= sccc_pkg::SCCC_RES_DONE;   // missing lines still succeed
      end
    end
  end

  // per-port configuration; system reset is deliberately not wired here
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      for (int i = 0; i < 4; i++) begin
        opt_cfg[i] <= sccc_pkg::sccc_opt_t'(`SCCC_AUX_RST);
        subst[i]   <= `SCCC_AUX_RST;
        wsize[i]   <= `SCCC_WS_8;
      end
    end else begin
      if (do_cfg) begin
        opt_cfg[pidx] <= sccc_pkg::sccc_opt_t'(cmd.first_aux_param);
        subst[pidx]   <= cmd.second_aux_param;
      end
      if (wr_ws) begin
        for (int i = 0; i < 4; i++) begin
          wsize[i] <= pwdata[2*i +: 2];
        end
      end
    end
  end

  // outgoing lines; only power-on resets them so they ride through rst
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      dtr_line           <= `SCCC_DTR_RST;
      rts_line           <= `SCCC_RTS_RST;
      transmit_data_line <= `SCCC_TXD_RST;   // mark when idle
    end else if (do_ctrl) begin
      // absent lines are silently skipped
      if (has_dtr && dtr_f == `SCCC_LC_ON) begin
        dtr_line[pidx] <= 1'b1;
      end else if (has_dtr && dtr_f == `SCCC_LC_OFF) begin
        dtr_line[pidx] <= 1'b0;
      end
      if (has_rts && rts_f == `SCCC_LC_ON) begin
        rts_line[0] <= 1'b1;
      end else if (has_rts && rts_f == `SCCC_LC_OFF) begin
        rts_line[0] <= 1'b0;
      end
      // a break is software holding space long enough
      if (txl_f == `SCCC_XM_SPACE) begin
        transmit_data_line[pidx] <= 1'b0;
      end else if (txl_f == `SCCC_XM_MARK) begin
        transmit_data_line[pidx] <= 1'b1;
      end
    end
  end

  // transmit path, stage 1: translation
  logic                lf_pend;   // a line feed is owed after a carriage return
  logic [1:0]          lf_port;   // port of the owed line feed
  logic                s1_valid;
  sccc_pkg::sccc_chr_t s1;

  wire logic take = tx_in_valid & tx_in_ready;
  wire sccc_pkg::sccc_opt_t topt = opt_cfg[tx_in.port];
  wire logic t_xlat = (topt.xlat == `SCCC_XL_LIGHT) | (topt.xlat == `SCCC_XL_HEAVY);
  wire logic t_endl = (tx_in.data == `SCCC_CH_ENDL);
  // heavy mode drops inverse video, control codes and codes above the bar
  wire logic t_bad  = tx_in.data[7] | (tx_in.data[6:0] < `SCCC_HV_LO) |
                      (tx_in.data[6:0] > `SCCC_HV_HI);
  wire logic t_keep = ~t_xlat | t_endl | (topt.xlat != `SCCC_XL_HEAVY) | ~t_bad;
  wire logic [7:0] t_data = ~t_xlat ? tx_in.data :
                            t_endl  ? `SCCC_CH_CR : {1'b0, tx_in.data[6:0]};
  wire logic want_lf = take & t_xlat & t_endl & topt.append_lf;

  // translation step; the owed line feed takes its own slot so it is converted too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_pend     <= 1'b0;
      lf_port     <= 2'h0;
      s1_valid    <= 1'b0;
      s1          <= '0;
      tx_in_ready <= 1'b1;
    end else begin
      tx_in_ready <= ~want_lf;              // stall intake for the line feed slot
      if (lf_pend) begin
        s1_valid <= 1'b1;
        s1       <= {`SCCC_CH_LF, lf_port};
        lf_pend  <= 1'b0;
      end else begin
        s1_valid <= take & t_keep;
        s1       <= {t_data, tx_in.port};
        lf_pend  <= want_lf;
        lf_port  <= tx_in.port;
      end
    end
  end

  // transmit path, stage 2: parity then truncation
  wire sccc_pkg::sccc_opt_t popt = opt_cfg[s1.port];
  wire logic p_ones = ^s1.data[6:0];
  wire logic p_bit  = (popt.out_par == `SCCC_OP_ODD)  ? ~p_ones :
                      (popt.out_par == `SCCC_OP_EVEN) ? p_ones :
                      (popt.out_par == `SCCC_OP_MARK) ? 1'b1 : s1.data[7];
  // truncation works on the parity result, so short words lose the parity bit
  wire logic [7:0] p_data = {p_bit, s1.data[6:0]} & ws_mask(wsize[s1.port]);

  // output register of the transmit path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_out_valid <= 1'b0;
      tx_out       <= '0;
    end else begin
      tx_out_valid <= s1_valid;
      tx_out       <= {p_data, s1.port};
    end
  end

  // receive path: expand, check, translate
  wire sccc_pkg::sccc_opt_t ropt = opt_cfg[rx_in.port];
  wire logic [7:0] r_exp = rx_in.data | ~ws_mask(wsize[rx_in.port]);
  wire logic r_ones = ^r_exp;
  wire logic r_err  = ((ropt.in_par == `SCCC_IP_ODD) & ~r_ones) |
                      ((ropt.in_par == `SCCC_IP_EVEN) & r_ones);
  wire logic [7:0] r_par = (ropt.in_par == `SCCC_IP_NONE) ? r_exp :
                           {1'b0, r_exp[6:0]};
  wire logic r_xlat = (ropt.xlat == `SCCC_XL_LIGHT) | (ropt.xlat == `SCCC_XL_HEAVY);
  wire logic [6:0] r_c7 = r_par[6:0];
  wire logic r_cr  = ({1'b0, r_c7} == `SCCC_CH_CR);
  wire logic r_bad = (r_c7 < `SCCC_HV_LO) | (r_c7 > `SCCC_HV_HI);
  wire logic [7:0] r_data = ~r_xlat ? r_par :
                            r_cr    ? `SCCC_CH_ENDL :
                            ((ropt.xlat == `SCCC_XL_HEAVY) & r_bad) ? subst[rx_in.port] :
                            {1'b0, r_c7};

  // a parity error still delivers the character, flagged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_out_valid <= 1'b0;
      rx_out       <= '0;
      rx_par_err   <= 1'b0;
    end else begin
      rx_out_valid <= rx_in_valid;
      rx_out       <= {r_data, rx_in.port};
      rx_par_err   <= rx_in_valid & r_err;
    end
  end

  // assertions
  property p_trunc;
    @(posedge clk) disable iff (rst || por)
    tx_out_valid |-> ((tx_out.data & ~ws_mask(wsize[tx_out.port])) == 8'h00);
  endproperty
  a_trunc: assert property (p_trunc) else $error("short word carries high bits");

  property p_fill;
    @(posedge clk) disable iff (rst || por)
    (rx_in_valid && wsize[rx_in.port] != `SCCC_WS_8 && ropt.xlat == `SCCC_XL_NONE &&
     ropt.in_par == `SCCC_IP_NONE) |=> (rx_out_valid && rx_out.data[7]);
  endproperty
  a_fill: assert property (p_fill) else $error("expanded input not filled with ones");

  property p_ws8;
    @(posedge clk) disable iff (rst || por)
    (rx_in_valid && wsize[rx_in.port] == `SCCC_WS_8 && ropt.xlat == `SCCC_XL_NONE &&
     ropt.in_par == `SCCC_IP_NONE) |=> (rx_out.data == $past(rx_in.data));
  endproperty
  a_ws8: assert property (p_ws8) else $error("eight-bit input altered");

  sequence s_endl_in;
    take && t_endl && topt.append_lf && topt.xlat == `SCCC_XL_LIGHT;
  endsequence
  sequence s_cr_lf;
    !tx_in_ready ##1 (tx_out_valid && tx_out.data[4:0] == 5'h0d) ##1
    (tx_out_valid && tx_out.data[4:0] == 5'h0a);
  endsequence
  property p_lf;
    @(posedge clk) disable iff (rst || por)
    s_endl_in |=> s_cr_lf;
  endproperty
  a_lf: assert property (p_lf) else $error("line feed not appended after return");

  property p_heavy_drop;
    @(posedge clk) disable iff (rst || por)
    (take && topt.xlat == `SCCC_XL_HEAVY && tx_in.data < 8'h20) |=> ##1 !tx_out_valid;
  endproperty
  a_heavy_drop: assert property (p_heavy_drop) else $error("heavy mode sent a control code");

  property p_busy;
    @(posedge clk) disable iff (rst || por)
    (wr_cmd && conc_s) |=> ($stable(dtr_line) && $stable(rts_line) &&
     $stable(transmit_data_line) && last_res == sccc_pkg::SCCC_RES_BUSY);
  endproperty
  a_busy: assert property (p_busy) else $error("command taken while busy");

  property p_pins;
    @(posedge clk) disable iff (por)
    (dtr_line[3] == 1'b0) && (rts_line[3:1] == 3'h0);
  endproperty
  a_pins: assert property (p_pins) else $error("missing line driven");

  property p_rts_on;
    @(posedge clk) disable iff (rst || por)
    (do_ctrl && has_rts && rts_f == `SCCC_LC_ON) |=> rts_line[0];
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not turned on");

  property p_rst_keep;
    @(posedge clk) disable iff (por)
    rst |=> ($stable(dtr_line) && $stable(rts_line) && $stable(transmit_data_line));
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("system reset moved a line");

  // packed views of the per-port option and substitute bytes, so one assertion can watch all ports at once
  wire logic [31:0] opt_all = {opt_cfg[3], opt_cfg[2], opt_cfg[1], opt_cfg[0]};
  wire logic [31:0] sub_all = {subst[3], subst[2], subst[1], subst[0]};

  // a command refused while busy must leave every port's translation setup alone
  property p_cfg_busy;
    @(posedge clk) disable iff (rst || por)
    (wr_cmd && conc_s) |=> ($stable(opt_all) && $stable(sub_all));
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("configuration taken while busy");

  // system reset must not clear the translation setup
  property p_rst_cfg;
    @(posedge clk) disable iff (por)
    rst |=> ($stable(opt_all) && $stable(sub_all));
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("system reset moved a configuration");

endmodule
`default_nettype wire

//--- sccc_periph.sv
// rs-232 peripheral model that feeds received characters to the controller and watches the transmit data line of port 1
`default_nettype none
module sccc_periph (
  input  wire logic                clk,
  input  wire logic                send_valid,
  input  wire sccc_pkg::sccc_chr_t send_chr,
  input  wire logic [3:0]          transmit_data_line,
  output var  logic                rx_in_valid,
  output var  sccc_pkg::sccc_chr_t rx_in,
  output var  int unsigned         space_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_in_valid  = 1'b0;
    rx_in        = '0;
    space_cycles = 0;
  end
  // one character a cycle; between characters the data toggles so a stale byte is never trusted
  always @(posedge clk) begin
    rx_in_valid <= send_valid;
    rx_in       <= send_valid ? send_chr : ~rx_in;
  end
  // length of the present space on port 1, so a break can be told apart from a data bit
  always @(posedge clk) begin
    space_cycles <= (transmit_data_line[0] === 1'b0) ? space_cycles + 1 : 0;
  end
endmodule
`default_nettype wire

//--- sccc_ctrl_test.sv
// self-checking bench of the character conversion controller
`include "sccc_consts.svh"
`default_nettype none
module sccc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHAR_CYCLES = 10;                 // assumed length of one character on the line
  logic                clk;
  logic                rst = 1'b1, por = 1'b1, conc_active = 1'b0;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata;
  logic                pready, pslverr, tx_in_ready, tx_out_valid, rx_in_valid, rx_out_valid, rx_par_err;
  logic                tx_in_valid = 1'b0, rx_send = 1'b0;
  sccc_pkg::sccc_chr_t tx_in = '0, rx_chr = '0;
  sccc_pkg::sccc_chr_t tx_out, rx_in, rx_out, rnd;
  logic [3:0]          dtr_line, rts_line, transmit_data_line;
  int unsigned         space_cycles;
  logic [32:0]         rd;                         // pslverr and prdata of the last access
  sccc_pkg::sccc_chr_t tx_q[$];                    // expected characters toward the line
  logic [10:0]         rx_q[$];                    // expected parity error and character toward the host
  logic [7:0]          opt[4] = '{default: 8'h00}; // shadow option bytes
  logic [7:0]          sub[4] = '{default: 8'h00}; // shadow substitute characters
  logic [1:0]          ws[4] = '{default: 2'h3};   // shadow word sizes, 8 bits after power-up
  int                  fails = 0, check_count = 0;

  sccc_ctrl u_sccc_ctrl (.clk(clk), .rst(rst), .por(por), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conc_active(conc_active), .tx_in_valid(tx_in_valid), .tx_in(tx_in), .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out(tx_out), .rx_in_valid(rx_in_valid), .rx_in(rx_in),
    .rx_out_valid(rx_out_valid), .rx_out(rx_out), .rx_par_err(rx_par_err), .dtr_line(dtr_line),
    .rts_line(rts_line), .transmit_data_line(transmit_data_line));
  sccc_periph u_sccc_periph (.clk(clk), .send_valid(rx_send), .send_chr(rx_chr),
    .transmit_data_line(transmit_data_line), .rx_in_valid(rx_in_valid), .rx_in(rx_in),
    .space_cycles(space_cycles));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // prints the counts and the verdict, then stops
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one comparison, counted and reported at once when it differs
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; a free cycle comes first so psel is never raised in the edge that lowered it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no answer time is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // command word: port number, substitute, option byte, code
  task automatic cmd(input logic [7:0] code, input logic [7:0] a1, input logic [7:0] a2, input logic [2:0] port);
    apb(1'b1, `SCCC_OFF_CMD, {5'h0, port, a2, a1, code});
  endtask

  // random legal option byte: one choice from each group, translation 0..2 only
  task automatic cfg_port(input int p);
    opt[p] = {1'b0, 1'($urandom), 2'($urandom % 3), 2'($urandom), 2'($urandom)};
    sub[p] = 8'($urandom);
    cmd(`SCCC_CODE_CFG, opt[p], sub[p], 3'(p + 1));
  endtask

  // expected line characters: translate, then parity, then truncate
  task automatic tx_push(input sccc_pkg::sccc_chr_t c);
    logic [7:0] o, q[$];
    o = opt[c.port];
    if (o[5:4] < `SCCC_XL_NONE && c.data == `SCCC_CH_ENDL) begin
      q.push_back(`SCCC_CH_CR);
      if (o[6]) q.push_back(`SCCC_CH_LF);
    end else if (o[5:4] == `SCCC_XL_LIGHT) q.push_back(c.data & 8'h7f);
    else if (o[5:4] != `SCCC_XL_HEAVY) q.push_back(c.data);
    else if (c.data >= `SCCC_HV_LO && c.data <= `SCCC_HV_HI) q.push_back(c.data);
    foreach (q[i]) begin
      case (o[1:0])
        `SCCC_OP_ODD:  q[i][7] = ~^q[i][6:0];
        `SCCC_OP_EVEN: q[i][7] = ^q[i][6:0];
        `SCCC_OP_MARK: q[i][7] = 1'b1;
        default: ;
      endcase
      tx_q.push_back({q[i] & (8'hff >> (2'h3 - ws[c.port])), c.port});
    end
  endtask

  // expected host characters: widen, then parity check, then translate
  task automatic rx_push(input sccc_pkg::sccc_chr_t c);
    logic [7:0] d, o;
    logic       e;
    o = opt[c.port];
    d = c.data | ~(8'hff >> (2'h3 - ws[c.port]));
    e = (o[3:2] == `SCCC_IP_ODD) ? ~^d : (o[3:2] == `SCCC_IP_EVEN) ? ^d : 1'b0;
    if (o[3:2] != `SCCC_IP_NONE) d[7] = 1'b0;
    if (o[5:4] < `SCCC_XL_NONE) begin
      d[7] = 1'b0;
      if (d == `SCCC_CH_CR) d = `SCCC_CH_ENDL;
      else if (o[5:4] == `SCCC_XL_HEAVY && (d < `SCCC_HV_LO || d > `SCCC_HV_HI)) d = sub[c.port];
    end
    rx_q.push_back({e, d, c.port});
  endtask

  // one host character, held until the controller takes it; the stall after an end of line is waited out
  task automatic tx_send(input sccc_pkg::sccc_chr_t c);
    int n;
    tx_in_valid <= 1'b1;
    tx_in       <= c;
    tx_push(c);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_in_ready !== 1'b1 && n < 8);
  endtask

  // compares every character that appears with the oldest expectation
  always @(posedge clk) begin
    if (tx_out_valid === 1'b1) begin
      if (tx_q.size() == 0) check(33'h1, 33'h0);
      else check(tx_out, tx_q.pop_front());
    end
    if (rx_out_valid === 1'b1) begin
      if (rx_q.size() == 0) check(33'h1, 33'h0);
      else check({rx_par_err, rx_out}, rx_q.pop_front());
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h1d438a15));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd_chk(`SCCC_OFF_LINES, 33'h00000f00);
    for (int p = 0; p < 4; p++) rd_chk(`SCCC_OFF_CFG0 + 8'(4 * p), 33'h0);
    rd_chk(`SCCC_OFF_WSIZE, 33'h000000ff);
    rd_chk(8'h40, 33'h100000000);
    for (int p = 1; p <= 4; p++) cmd(`SCCC_CODE_CTRL, 8'hf2, 8'h5a, 3'(p));
    rd_chk(`SCCC_OFF_LINES, 33'h00000017);
    rd_chk(`SCCC_OFF_STAT, 33'h1);
    repeat (CHAR_CYCLES) @(posedge clk);
    check(33'(space_cycles > CHAR_CYCLES), 33'h1);
    cmd(`SCCC_CODE_CTRL, 8'h23, 8'h00, 3'h0);
    cmd(`SCCC_CODE_CTRL, 8'h80, 8'h00, 3'h2);
    cmd(`SCCC_CODE_CTRL, 8'hc3, 8'h00, 3'h5);
    rd_chk(`SCCC_OFF_STAT, 33'h3);
    rd_chk(`SCCC_OFF_LINES, 33'h00000105);
    for (int p = 0; p < 4; p++) cfg_port(p);
    // commands while a concurrent transfer runs are refused
    conc_active <= 1'b1;
    repeat (3) @(posedge clk);
    cmd(`SCCC_CODE_CFG, 8'h2a, 8'h11, 3'h1);
    rd_chk(`SCCC_OFF_STAT, 33'h6);
    cmd(`SCCC_CODE_CTRL, 8'hc3, 8'h00, 3'h4);
    rd_chk(`SCCC_OFF_STAT, 33'h6);
    conc_active <= 1'b0;
    // system reset leaves lines and configuration alone
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SCCC_OFF_LINES, 33'h00000105);
    for (int p = 0; p < 4; p++) rd_chk(`SCCC_OFF_CFG0 + 8'(4 * p), {17'h0, sub[p], opt[p]});
    // character streams under random configurations and word sizes
    for (int r = 0; r < 8; r++) begin
      for (int p = 0; p < 4; p++) cfg_port(p);
      foreach (ws[p]) ws[p] = 2'($urandom);
      apb(1'b1, `SCCC_OFF_WSIZE, {24'h0, ws[3], ws[2], ws[1], ws[0]});
      for (int i = 0; i < 12; i++) tx_send({($urandom % 3 == 0) ? `SCCC_CH_ENDL : 8'($urandom), 2'($urandom)});
      tx_in_valid <= 1'b0;
      for (int i = 0; i < 12; i++) begin
        rnd = {8'($urandom), 2'($urandom)};
        rx_send <= 1'b1;
        rx_chr  <= rnd;
        rx_push(rnd);
        @(posedge clk);
      end
      rx_send <= 1'b0;
      repeat (4) @(posedge clk);
      check(33'(tx_q.size() + rx_q.size()), 33'h0);
    end
    finish_test();
  end

  // cuts a hang short; the run needs far fewer cycles than this
  initial begin
    #(8 * 60000);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
